//--- src/bst_tap.sv
// boundary-scan test access logic: tap, instruction decode, data registers
// assumes tck from the tester, system side on i_clock, shared async reset
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - codes 00000, 00001, 00111 put the boundary register on the scan path.
// - codes 00010 and 00011 put user chain one or two on the path.
// - codes 00100 and 00101 open config readback and config write.
// - codes 01000 and 01001 shift out user code and device code.
// - code 01010 floats every output and uses the bypass bit.
// - code 01100 steps start-up on tck only when tck is chosen.
// - code 11111 is the one-bit bypass; other codes are unused.
// - user chain codes work only after configuration; others always.
// - three cells per io block, order input, output, three-state.
// - input-only pins add one cell each, after all io block cells.
// - data capture loads every cell from current pin and logic values.
// - every io block is a three-state bidirectional pin, one chain.
// - device code is 32 bits, version on top, lsb always one.
// - user code comes from the bitstream, valid after configuration.
// - select outputs decode user codes; user return data reaches tdo.
// - per-chain clocks, common scan input, reset/shift/update outputs.
module bst_tap #(
    parameter int N_BLK  = 8,
    parameter int N_INO  = 2,
    parameter logic [bst_pkg::ID_VER_W-1:0] ID_VER = 4'h1, // arbitrary
    parameter logic [bst_pkg::ID_FAM_W-1:0] ID_FAM = 7'h2A, // arbitrary
    parameter logic [bst_pkg::ID_ROW_W-1:0] ID_ROW = 9'h011, // arbitrary
    parameter logic [bst_pkg::ID_MFR_W-1:0] ID_MFR = 11'h155 // arbitrary
) (
    input  wire logic              i_clock,
    input  wire logic              i_resetn,
    input  wire logic              i_config_done,
    input  wire logic              i_startup_tck_sel,
    input  wire logic [31:0]       i_user_code,
    input  wire logic              i_tck,
    input  wire logic              i_tms,
    input  wire logic              i_tdi,
    output logic                   o_tdo,
    output logic                   o_tdo_en,
    input  wire logic [N_BLK-1:0]  i_pin_in,
    input  wire logic [N_INO-1:0]  i_ino_pin,
    input  wire logic [N_BLK-1:0]  i_core_out,
    input  wire logic [N_BLK-1:0]  i_core_oe,
    output logic      [N_BLK-1:0]  o_pin_out,
    output logic      [N_BLK-1:0]  o_pin_oe,
    output logic      [N_BLK-1:0]  o_core_in,
    output logic      [N_INO-1:0]  o_ino_core_in,
    output logic                   o_cfg_read_sel,
    output logic                   o_cfg_write_sel,
    input  wire logic              i_cfg_return,
    output logic                   o_startup_step,
    output logic                   o_user_chain_one_select,
    output logic                   o_user_chain_two_select,
    input  wire logic              i_user_chain_one_return,
    input  wire logic              i_user_chain_two_return,
    output logic                   o_user_chain_one_clock,
    output logic                   o_user_chain_two_clock,
    output logic                   o_scan_tdi,
    output logic                   o_tap_reset,
    output logic                   o_tap_shift,
    output logic                   o_tap_update
);
    import bst_pkg::*;
    localparam int BSR_W = CELLS_BLK * N_BLK + N_INO;

    // system-side source flops, so only clean levels cross to tck
    logic        done_q, done_d, tcksel_q, tcksel_d;
    logic [31:0] ucode_q, ucode_d;
    always_comb begin
        done_d   = i_config_done;
        tcksel_d = i_startup_tck_sel;
        ucode_d  = i_config_done ? ucode_q : i_user_code;
    end
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            done_q   <= 1'b0;
            tcksel_q <= 1'b0;
            ucode_q  <= 32'h0;
        end else begin
            done_q   <= done_d;
            tcksel_q <= tcksel_d;
            ucode_q  <= ucode_d;
        end
    end

    // two-flop synchronisers into tck; user code is frozen once done is set,
    // so it is only read after the synchronised done flag is high
    logic [1:0] done_s, tcksel_s;
    logic [N_BLK-1:0] pin_m, pin_s, cout_m, cout_s, coe_m, coe_s;
    logic [N_INO-1:0] ino_m, ino_s;
    always_ff @(posedge i_tck or negedge i_resetn) begin
        if (!i_resetn) begin
            done_s   <= 2'h0;
            tcksel_s <= 2'h0;
            pin_m    <= '0;
            pin_s    <= '0;
            cout_m   <= '0;
            cout_s   <= '0;
            coe_m    <= '0;
            coe_s    <= '0;
            ino_m    <= '0;
            ino_s    <= '0;
        end else begin
            done_s   <= {done_s[0], done_q};
            tcksel_s <= {tcksel_s[0], tcksel_q};
            pin_m    <= i_pin_in;
            pin_s    <= pin_m;
            cout_m   <= i_core_out;
            cout_s   <= cout_m;
            coe_m    <= i_core_oe;
            coe_s    <= coe_m;
            ino_m    <= i_ino_pin;
            ino_s    <= ino_m;
        end
    end
    logic cfg_ok;
    assign cfg_ok = done_s[1];

    // tap controller
    bst_state_e st_q, st_d;
    always_comb begin
        unique case (st_q)
            ST_TLR:    st_d = i_tms ? ST_TLR    : ST_RTI;
            ST_RTI:    st_d = i_tms ? ST_SEL_DR : ST_RTI;
            ST_SEL_DR: st_d = i_tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: st_d = i_tms ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR:  st_d = i_tms ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: st_d = i_tms ? ST_UPD_DR : ST_PA_DR;
            ST_PA_DR:  st_d = i_tms ? ST_EX2_DR : ST_PA_DR;
            ST_EX2_DR: st_d = i_tms ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: st_d = i_tms ? ST_SEL_DR : ST_RTI;
            ST_SEL_IR: st_d = i_tms ? ST_TLR    : ST_CAP_IR;
            ST_CAP_IR: st_d = i_tms ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR:  st_d = i_tms ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: st_d = i_tms ? ST_UPD_IR : ST_PA_IR;
            ST_PA_IR:  st_d = i_tms ? ST_EX2_IR : ST_PA_IR;
            ST_EX2_IR: st_d = i_tms ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: st_d = i_tms ? ST_SEL_DR : ST_RTI;
        endcase
    end

    // instruction path: shifter, then active instruction at update
    logic [4:0] irs_q, irs_d, ir_q, ir_d;
    always_comb begin
        irs_d = irs_q;
        ir_d  = ir_q;
        if (st_q == ST_CAP_IR)
            irs_d = IR_CAPTURE;
        else if (st_q == ST_SH_IR)
            irs_d = {i_tdi, irs_q[4:1]};
        if (st_q == ST_TLR)
            ir_d = INS_IDCODE;
        else if (st_q == ST_UPD_IR)
            ir_d = irs_q;
    end

    // instruction decode
    logic sel_bsr, sel_u1, sel_u2, sel_id, sel_uc;
    assign sel_bsr = (ir_q == INS_EXTEST) || (ir_q == INS_SAMPLE)
                   || (ir_q == INS_INTEST);
    // user chains live only after configuration
    assign sel_u1 = (ir_q == INS_UCH1) && cfg_ok;
    assign sel_u2 = (ir_q == INS_UCH2) && cfg_ok;
    assign sel_id = (ir_q == INS_IDCODE);
    assign sel_uc = (ir_q == INS_USRCODE);

    // data registers; unassigned and unusable codes fall back to bypass
    logic [BSR_W-1:0] bsr_q, bsr_d, upd_q, upd_d, cap;
    logic [ID_W-1:0]  dr32_q, dr32_d;
    logic             byp_q, byp_d;
    // per block order is input, output, three-state
    // input-only pins append a single input cell
    // every block handled alike, configured or not
    always_comb begin
        cap = '0;
        for (int i = 0; i < N_BLK; i++) begin
            cap[CELLS_BLK*i+CELL_IN]  = pin_s[i];
            cap[CELLS_BLK*i+CELL_OUT] = cout_s[i];
            cap[CELLS_BLK*i+CELL_OE]  = coe_s[i];
        end
        for (int j = 0; j < N_INO; j++)
            cap[CELLS_BLK*N_BLK+j] = ino_s[j];
    end
    always_comb begin
        bsr_d  = bsr_q;
        upd_d  = upd_q;
        dr32_d = dr32_q;
        byp_d  = byp_q;
        if (st_q == ST_CAP_DR && sel_bsr)
            bsr_d = cap;
        else if (st_q == ST_SH_DR && sel_bsr)
            bsr_d = {i_tdi, bsr_q[BSR_W-1:1]};
        if (st_q == ST_TLR)
            upd_d = '0;
        else if (st_q == ST_UPD_DR && sel_bsr)
            upd_d = bsr_q;
        if (st_q == ST_CAP_DR && sel_id)
            dr32_d = {ID_VER, ID_FAM, ID_ROW, ID_MFR, 1'b1};
        else if (st_q == ST_CAP_DR && sel_uc)
            dr32_d = cfg_ok ? ucode_q : 32'h0;
        else if (st_q == ST_SH_DR && (sel_id || sel_uc))
            dr32_d = {i_tdi, dr32_q[ID_W-1:1]};
        if (st_q == ST_CAP_DR)
            byp_d = 1'b0;
        else if (st_q == ST_SH_DR)
            byp_d = i_tdi;
    end
    always_ff @(posedge i_tck or negedge i_resetn) begin
        if (!i_resetn) begin
            st_q   <= ST_TLR;
            irs_q  <= IR_CAPTURE;
            ir_q   <= INS_IDCODE;
            bsr_q  <= '0;
            upd_q  <= '0;
            dr32_q <= '0;
            byp_q  <= 1'b0;
        end else begin
            st_q   <= st_d;
            irs_q  <= irs_d;
            ir_q   <= ir_d;
            bsr_q  <= bsr_d;
            upd_q  <= upd_d;
            dr32_q <= dr32_d;
            byp_q  <= byp_d;
        end
    end

    // pin and core side of the boundary cells
    logic ext, intst;
    assign ext   = (ir_q == INS_EXTEST);
    assign intst = (ir_q == INS_INTEST);
    always_comb begin
        for (int i = 0; i < N_BLK; i++) begin
            o_pin_out[i] = ext ? upd_q[CELLS_BLK*i+CELL_OUT] : i_core_out[i];
            o_pin_oe[i]  = ext ? upd_q[CELLS_BLK*i+CELL_OE] : i_core_oe[i];
            o_core_in[i] = intst ? upd_q[CELLS_BLK*i+CELL_IN] : i_pin_in[i];
        end
        for (int j = 0; j < N_INO; j++)
            o_ino_core_in[j] = intst ? upd_q[CELLS_BLK*N_BLK+j] : i_ino_pin[j];
        if (ir_q == INS_HIGHZ)
            o_pin_oe = '0;
    end

    assign o_cfg_read_sel  = (ir_q == INS_CFGRD);
    assign o_cfg_write_sel = (ir_q == INS_CFGWR);
    assign o_user_chain_one_select = sel_u1;
    assign o_user_chain_two_select = sel_u2;
    // shared scan input and tap state outputs
    assign o_scan_tdi   = i_tdi;
    assign o_tap_reset  = (st_q == ST_TLR);
    assign o_tap_shift  = (st_q == ST_SH_DR);
    assign o_tap_update = (st_q == ST_UPD_DR);

    // one step per tck in idle, gated by source choice
    logic step_q, step_d;
    always_comb begin
        step_d = (ir_q == INS_STARTUP) && tcksel_s[1] && (st_d == ST_RTI);
    end

    // tdo mux and falling-edge outputs
    logic tdo_q, tdo_d, ten_q, ten_d, uck1_q, uck1_d, uck2_q, uck2_d;
    logic dr_act;
    assign dr_act = (st_q == ST_CAP_DR) || (st_q == ST_SH_DR);
    always_comb begin
        // user return data picked per chain
        if (st_q == ST_SH_IR)
            tdo_d = irs_q[0];
        else if (sel_bsr)
            tdo_d = bsr_q[0];
        else if (sel_id || sel_uc)
            tdo_d = dr32_q[0];
        else if (sel_u1)
            tdo_d = i_user_chain_one_return;
        else if (sel_u2)
            tdo_d = i_user_chain_two_return;
        else if (o_cfg_read_sel)
            tdo_d = i_cfg_return;
        else
            tdo_d = byp_q;
        ten_d  = (st_q == ST_SH_IR) || (st_q == ST_SH_DR);
        // strobes high across capture and shift for the chain
        uck1_d = sel_u1 && dr_act;
        uck2_d = sel_u2 && dr_act;
    end
    always_ff @(posedge i_tck or negedge i_resetn) begin
        if (!i_resetn)
            step_q <= 1'b0;
        else
            step_q <= step_d;
    end
    always_ff @(negedge i_tck or negedge i_resetn) begin
        if (!i_resetn) begin
            tdo_q  <= 1'b0;
            ten_q  <= 1'b0;
            uck1_q <= 1'b0;
            uck2_q <= 1'b0;
        end else begin
            tdo_q  <= tdo_d;
            ten_q  <= ten_d;
            uck1_q <= uck1_d;
            uck2_q <= uck2_d;
        end
    end
    assign o_tdo                  = tdo_q;
    assign o_tdo_en               = ten_q;
    assign o_startup_step         = step_q;
    assign o_user_chain_one_clock = uck1_q;
    assign o_user_chain_two_clock = uck2_q;

    // checks, all on tck
    tlr_entry_a: assert property (@(posedge i_tck) disable iff (!i_resetn)
        (i_tms)[*5] |=> st_q == ST_TLR) else $error("tms high did not reset tap");
    byp_cap_a: assert property (@(posedge i_tck) disable iff (!i_resetn)
        st_q == ST_CAP_DR |=> !byp_q) else $error("bypass did not capture zero");
    id_word_a: assert property (@(posedge i_tck) disable iff (!i_resetn)
        (st_q == ST_CAP_DR && sel_id) |=> dr32_q[0] && dr32_q[31:28] == ID_VER)
        else $error("device code capture wrong");
    highz_oe_a: assert property (@(posedge i_tck) disable iff (!i_resetn)
        ir_q == INS_HIGHZ |-> o_pin_oe == '0) else $error("output enabled in highz");
    user_gate_a: assert property (@(posedge i_tck) disable iff (!i_resetn)
        (o_user_chain_one_select || o_user_chain_two_select) |-> done_s[1])
        else $error("user chain selected before configuration");
    user_sel_a: assert property (@(posedge i_tck) disable iff (!i_resetn)
        (ir_q == INS_UCH2 && done_s[1]) |-> o_user_chain_two_select)
        else $error("user chain two not selected");
    ext_drive_a: assert property (@(posedge i_tck) disable iff (!i_resetn)
        (ir_q == INS_EXTEST) |-> o_pin_out[0] == upd_q[CELL_OUT])
        else $error("extest not driving from update cells");
    cfg_sel_a: assert property (@(posedge i_tck) disable iff (!i_resetn)
        o_cfg_read_sel |-> ir_q == INS_CFGRD && !o_cfg_write_sel)
        else $error("config read select wrong");
    step_gate_a: assert property (@(posedge i_tck) disable iff (!i_resetn)
        o_startup_step |-> $past(ir_q) == INS_STARTUP && $past(tcksel_s[1]))
        else $error("start-up stepped without selection");
    bsr_cap_a: assert property (@(posedge i_tck) disable iff (!i_resetn)
        (st_q == ST_CAP_DR && sel_bsr) |=> bsr_q[CELL_IN] == $past(pin_s[0]))
        else $error("boundary capture missed pin");
    uc_gate_a: assert property (@(posedge i_tck) disable iff (!i_resetn)
        (st_q == ST_CAP_DR && sel_uc && !done_s[1]) |=> dr32_q == 32'h0)
        else $error("user code visible before configuration");
endmodule : bst_tap

`default_nettype wire

//--- src/bst_pkg.sv
// constants for the boundary-scan access logic
// assumes a single test port clocked by the tester's tck
package bst_pkg;
    localparam int IR_W = 5;
    // instruction codes
    localparam logic [4:0] INS_EXTEST  = 5'h00;
    localparam logic [4:0] INS_SAMPLE  = 5'h01;
    localparam logic [4:0] INS_UCH1    = 5'h02;
    localparam logic [4:0] INS_UCH2    = 5'h03;
    localparam logic [4:0] INS_CFGRD   = 5'h04;
    localparam logic [4:0] INS_CFGWR   = 5'h05;
    localparam logic [4:0] INS_INTEST  = 5'h07;
    localparam logic [4:0] INS_USRCODE = 5'h08;
    localparam logic [4:0] INS_IDCODE  = 5'h09;
    localparam logic [4:0] INS_HIGHZ   = 5'h0A;
    localparam logic [4:0] INS_STARTUP = 5'h0C;
    localparam logic [4:0] INS_BYPASS  = 5'h1F;
    // value loaded into the instruction shifter on capture
    localparam logic [4:0] IR_CAPTURE  = 5'h01;
    // identification word fields, msb to lsb, then a fixed one
    localparam int ID_W      = 32;
    localparam int ID_VER_W  = 4;
    localparam int ID_FAM_W  = 7;
    localparam int ID_ROW_W  = 9;
    localparam int ID_MFR_W  = 11;
    localparam int CELLS_BLK = 3;
    localparam int CELL_IN   = 0;
    localparam int CELL_OUT  = 1;
    localparam int CELL_OE   = 2;
    localparam int TLR_TMS_N = 5;
    typedef enum logic [3:0] {
        ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR,
        ST_PA_DR, ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR,
        ST_SH_IR, ST_EX1_IR, ST_PA_IR, ST_EX2_IR, ST_UPD_IR
    } bst_state_e;
endpackage : bst_pkg

//--- verif/bst_tester_model.sv
// tester model for the test port: owns tck, tms and tdi, reads tdo
// assumes the tap samples on rising tck and moves tdo on falling tck
`timescale 1ns/100ps
`default_nettype none
module bst_tester_model (
    output logic      o_tck,
    output logic      o_tms,
    output logic      o_tdi,
    input  wire logic i_tdo
);
    // tck stands low between frames, as a real pod would leave it
    initial begin
        o_tck = 1'b0;
        o_tms = 1'b1;
        o_tdi = 1'b0;
    end
    // rising sample point
    // one 15 ns tck cycle; tdo read before the rise that moves the tap
    task automatic step(input logic t_ms, input logic t_di, output logic t_do);
        #1 o_tms = t_ms;
        o_tdi = t_di;
        #6.5 t_do = i_tdo;
        o_tck = 1'b1;
        #7.5 o_tck = 1'b0;
    endtask : step
    // idle cycles in run-test/idle; tdi toggles so a stale bit shows
    task automatic idle(input int n);
        logic b;
        repeat (n) step(1'b0, ~o_tdi, b);
    endtask : idle
    task automatic tap_reset();
        logic b;
        repeat (5) step(1'b1, ~o_tdi, b);
        step(1'b0, ~o_tdi, b);
    endtask : tap_reset
    // tms walk order
    // full scan from idle back to idle, lsb first in and out
    task automatic scan(input bit ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout);
        logic b;
        dout = '0;
        step(1'b1, ~o_tdi, b);
        if (ir) step(1'b1, ~o_tdi, b);
        step(1'b0, ~o_tdi, b);
        step(1'b0, ~o_tdi, b);
        for (int k = 0; k < n; k++) begin
            step(k == n - 1, din[k], b);
            dout[k] = b;
        end
        step(1'b1, ~o_tdi, b);
        step(1'b0, ~o_tdi, b);
    endtask : scan
endmodule : bst_tester_model
`default_nettype wire

//--- verif/tb.sv
// self-checking bench for the boundary-scan access logic
// assumes the tester model owns tck; system inputs change on i_clock
`timescale 1ns/100ps
`default_nettype none
module tb;
    import bst_pkg::*;
    logic        i_clock  = 1'b0;
    logic        i_resetn = 1'b0;
    logic        done_r   = 1'b0;
    logic        tsel_r   = 1'b0;
    logic [31:0] ucode_r  = '0;
    logic [7:0]  pin_r    = '0;
    logic [1:0]  ino_r    = '0;
    logic [7:0]  cout_r   = '0;
    logic [7:0]  coe_r    = '0;
    logic        cfg_r    = 1'b0;
    logic        ret1_r   = 1'b0;
    logic        ret2_r   = 1'b0;
    logic        tck, tms, tdi, tdo, tdo_en, rsel, wsel, stp;
    logic        user_chain_one_select, user_chain_two_select, ck1, ck2, stdi, trst, tsh, tupd;
    logic [7:0]  pout, poe, cin;
    logic [1:0]  icin;
    logic [31:0] rd;
    int          bad_count = 0;
    int          checks    = 0;
    int          cycles    = 0;
    int          step_cnt  = 0;
    int          sh_cnt    = 0;
    int          upd_cnt   = 0;
    int          ck_cnt    = 0;
    int          en_cnt    = 0;
    localparam logic [31:0] PAT = 32'h02B71C93;
    localparam logic [31:0] ID_EXP = {4'h1, 7'h2A, 9'h011, 11'h155, 1'b1};

    bst_tap bst_tap_inst (.i_clock(i_clock), .i_resetn(i_resetn), .i_config_done(done_r),
        .i_startup_tck_sel(tsel_r), .i_user_code(ucode_r), .i_tck(tck), .i_tms(tms),
        .i_tdi(tdi), .o_tdo(tdo), .o_tdo_en(tdo_en), .i_pin_in(pin_r), .i_ino_pin(ino_r),
        .i_core_out(cout_r), .i_core_oe(coe_r), .o_pin_out(pout), .o_pin_oe(poe),
        .o_core_in(cin), .o_ino_core_in(icin), .o_cfg_read_sel(rsel),
        .o_cfg_write_sel(wsel), .i_cfg_return(cfg_r), .o_startup_step(stp),
        .o_user_chain_one_select(user_chain_one_select), .o_user_chain_two_select(user_chain_two_select),
        .i_user_chain_one_return(ret1_r), .i_user_chain_two_return(ret2_r),
        .o_user_chain_one_clock(ck1), .o_user_chain_two_clock(ck2), .o_scan_tdi(stdi),
        .o_tap_reset(trst), .o_tap_shift(tsh), .o_tap_update(tupd));
    bst_tester_model bst_tester_model_inst (.o_tck(tck), .o_tms(tms), .o_tdi(tdi),
        .i_tdo(tdo));

    // 50 MHz system clock
    initial begin
        forever #10 i_clock = ~i_clock;
    end
    // hang guard: the whole run needs far fewer cycles than this
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            complete_run();
        end
    end
    // rising-edge outputs counted on the falling edge, where they are settled
    always @(negedge tck) begin
        if (stp === 1'b1) step_cnt++;
        if (tsh === 1'b1) sh_cnt++;
        if (tupd === 1'b1) upd_cnt++;
    end
    // falling-edge outputs counted on the rising edge
    always @(posedge tck) begin
        if ((ck1 | ck2) === 1'b1) ck_cnt++;
        if (tdo_en === 1'b1) en_cnt++;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic ir(input logic [4:0] c);
        bst_tester_model_inst.scan(1'b1, 5, 32'(c), rd);
    endtask : ir
    task automatic dr(input int n, input logic [31:0] d);
        bst_tester_model_inst.scan(1'b0, n, d, rd);
    endtask : dr
    task automatic done_test(input string nm);
        $display("test %s finished", nm);
    endtask : done_test
    // capture image: per block in, out, oe, then input-only pads
    function automatic logic [31:0] cap_exp();
        logic [31:0] e;
        e = '0;
        for (int i = 0; i < 8; i++) begin
            e[3*i]   = pin_r[i];
            e[3*i+1] = cout_r[i];
            e[3*i+2] = coe_r[i];
        end
        e[24] = ino_r[0];
        e[25] = ino_r[1];
        return e;
    endfunction : cap_exp

    task automatic t_idcode();
        chk(32'(trst), 32'h1);
        bst_tester_model_inst.tap_reset();
        dr(32, 32'h0);
        chk(rd, ID_EXP);
        ir(INS_IDCODE);
        chk(rd, 32'(IR_CAPTURE));
        dr(32, 32'h0);
        chk(rd, ID_EXP);
        done_test("idcode");
    endtask : t_idcode
    // user chains act as bypass until configuration is done
    task automatic t_user(input bit cfg);
        for (int c = 0; c < 2; c++) begin
            @(posedge i_clock);
            ret1_r <= (c == 0);
            ret2_r <= (c == 1);
            ir(c == 0 ? INS_UCH1 : INS_UCH2);
            chk(32'({user_chain_two_select, user_chain_one_select}), cfg ? 32'(c + 1) : 32'h0);
            sh_cnt = 0;
            upd_cnt = 0;
            ck_cnt = 0;
            en_cnt = 0;
            dr(8, 32'h0);
            chk(rd, cfg ? 32'hFF : 32'h0);
            chk(32'(ck_cnt), cfg ? 32'h9 : 32'h0);
            chk(32'(sh_cnt), 32'h8);
            chk(32'(upd_cnt), 32'h1);
            chk(32'(en_cnt), 32'h8);
            chk(32'(stdi), 32'(tdi));
        end
        ir(INS_USRCODE);
        dr(32, 32'h0);
        chk(rd, cfg ? 32'hA5C31E0F : 32'h0);
        done_test("user");
    endtask : t_user
    task automatic t_boundary();
        ir(INS_SAMPLE);
        dr(26, PAT);
        chk(rd, cap_exp());
        chk(32'({poe, pout}), 32'({coe_r, cout_r}));
        ir(INS_EXTEST);
        for (int i = 0; i < 8; i++) begin
            chk(32'({poe[i], pout[i]}), 32'({PAT[3*i+2], PAT[3*i+1]}));
        end
        dr(26, PAT);
        chk(rd, cap_exp());
        ir(INS_INTEST);
        for (int i = 0; i < 8; i++) begin
            chk(32'(cin[i]), 32'(PAT[3*i]));
        end
        chk(32'(icin), 32'(PAT[25:24]));
        done_test("boundary");
    endtask : t_boundary
    task automatic t_cfg();
        ir(INS_CFGRD);
        chk(32'({wsel, rsel}), 32'h1);
        dr(8, 32'h0);
        chk(rd, 32'hFF);
        ir(INS_CFGWR);
        chk(32'({wsel, rsel}), 32'h2);
        done_test("config");
    endtask : t_cfg
    task automatic t_startup();
        for (int s = 0; s < 2; s++) begin
            @(posedge i_clock);
            tsel_r <= s[0];
            bst_tester_model_inst.idle(4);
            ir(INS_STARTUP);
            step_cnt = 0;
            bst_tester_model_inst.idle(10);
            if (s == 1) chk(32'(step_cnt >= 8 && step_cnt <= 12), 32'h1);
            else chk(32'(step_cnt), 32'h0);
        end
        done_test("startup");
    endtask : t_startup
    // bypass, a reserved code and high-z all give a one-bit path
    task automatic t_bypass();
        logic [4:0] codes [3];
        codes = '{INS_BYPASS, 5'h06, INS_HIGHZ};
        foreach (codes[i]) begin
            ir(codes[i]);
            dr(8, 32'hB4);
            chk(rd, 32'h68);
        end
        chk(32'(poe), 32'h0);
        done_test("bypass");
    endtask : t_bypass

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run

    initial begin
        repeat (4) @(posedge i_clock);
        i_resetn <= 1'b1;
        pin_r    <= 8'h5A;
        cout_r   <= 8'hC3;
        coe_r    <= 8'h0F;
        ino_r    <= 2'b10;
        cfg_r    <= 1'b1;
        ucode_r  <= 32'hA5C31E0F;
        @(posedge i_clock);
        t_idcode();
        t_user(1'b0);
        @(posedge i_clock);
        done_r <= 1'b1;
        bst_tester_model_inst.idle(4);
        @(posedge i_clock);
        ucode_r <= 32'h0;
        t_user(1'b1);
        t_boundary();
        t_cfg();
        t_startup();
        t_bypass();
        complete_run();
    end
endmodule : tb
`default_nettype wire
